// *** pkg/gpp_pkg.sv ***
// Purpose: Shared constants and carriers for the general purpose I/O port.
// Assumes: Eight pins per port, one register set per port.
// Notes: Register selects are local codes for the plain write/read port.
package gpp_pkg;
  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int unsigned GPP_PINS = 8;
  localparam int unsigned GPP_PORTS = 5;
  localparam int unsigned GPP_SEL_W = 4;
  // ----------------------------------------------------------------
  // Register selects
  // ----------------------------------------------------------------
  localparam logic [3:0] GPP_SEL_PIN_LEVEL = 4'h0;
  localparam logic [3:0] GPP_SEL_LATCH = 4'h1;
  localparam logic [3:0] GPP_SEL_DIR = 4'h2;
  localparam logic [3:0] GPP_SEL_ANALOG = 4'h3;
  localparam logic [3:0] GPP_SEL_PULLUP = 4'h4;
  localparam logic [3:0] GPP_SEL_THRESH = 4'h5;
  localparam logic [3:0] GPP_SEL_SLEW = 4'h6;
  localparam logic [3:0] GPP_SEL_OPEN_DRAIN = 4'h7;
  localparam logic [3:0] GPP_SEL_I2C_PAD = 4'h8;
  localparam logic [3:0] GPP_SEL_EDGE_RISE = 4'h9;
  localparam logic [3:0] GPP_SEL_EDGE_FALL = 4'ha;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] GPP_RST_LATCH = 8'h00;
  localparam logic [7:0] GPP_RST_DIR = 8'hff;
  localparam logic [7:0] GPP_RST_ANALOG = 8'hff;
  localparam logic [7:0] GPP_RST_PULLUP = 8'h00;
  localparam logic [7:0] GPP_RST_THRESH = 8'hff;
  localparam logic [7:0] GPP_RST_SLEW = 8'hff;
  localparam logic [7:0] GPP_RST_ZERO = 8'h00;
  // I2C pad control field positions.
  localparam int unsigned GPP_I2C_SLEW_BIT = 0;
  localparam int unsigned GPP_I2C_PULL_BIT = 1;
  localparam int unsigned GPP_I2C_THR_BIT = 2;
  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  // One register access from the core.
  typedef struct packed {
    logic wr_en;
    logic [2:0] port;
    logic [3:0] sel;
    logic [7:0] wdata;
  } gpp_req_s;
  // Pad controls driven to one port's pads.
  typedef struct packed {
    logic [7:0] drive_n;
    logic [7:0] out_val;
    logic [7:0] pull_up;
    logic [7:0] slew_lim;
    logic [7:0] i2c_slew;
    logic [7:0] i2c_pull;
  } gpp_pad_s;
  // Pin owner after the priority decision.
  typedef enum logic [1:0] {
    GPP_OWN_LATCH = 2'b00,
    GPP_OWN_PERIPH = 2'b01,
    GPP_OWN_ANALOG_OUT = 2'b10,
    GPP_OWN_CONFIG = 2'b11
  } gpp_own_e;
endpackage : gpp_pkg

// *** core/gpp_port.sv ***
// Purpose: General purpose I/O port register set, pad control and pin priority.
// Assumes: Pin levels are asynchronous; all other inputs are on ref_clk.
// Notes: Outputs are registered, so pad controls lag a write by one cycle.
//
// What this block does
// - Port reads give pins, writes load latch.
// - Latch keeps last write from either register.
// - Latch write same; latch read returns latch.
// - Direction one tristates, zero drives latch.
// - Direction still governs driver for analog inputs.
// - Analog select forces digital input to zero.
// - Analog select leaves output functions untouched.
// - Analog select bits reset to analog.
// - Pull-up bit one enables weak pull-up.
// - Threshold select feeds reads and edge detect.
// - Slew bit one limits output slew rate.
// - Open-drain bit one makes output sink only.
// - Each pin interrupts on chosen rising/falling edge.
// - I2C pads get slew, pull-up, SMBus threshold.
// - Peripheral owns output; pin still readable.
// - Reset sources outputs from data latch.
// - Analog output tristates the digital driver.
// - Priority: config, analog out, peripheral, latch.
// - Threshold one Schmitt, zero TTL.
// - Pull-up off for outputs; bit kept.
// - Unimplemented pin bits read zero.
`timescale 1ns/10ps
module gpp_port (
  // Clock, reset and enable.
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clk_en,
  // Register access and read data.
  input wire gpp_pkg::gpp_req_s req,
  output logic [7:0] rdata,
  // Pins: Schmitt, TTL and I2C receiver outputs per port.
  input wire logic [39:0] pin_st,
  input wire logic [39:0] pin_ttl,
  input wire logic [39:0] pin_i2c,
  // Implemented pin mask per port.
  input wire logic [39:0] pin_impl,
  // Peripheral and analog owners per pin.
  input wire logic [39:0] cfg_own,
  input wire logic [39:0] cfg_out,
  input wire logic [39:0] cfg_oe_n,
  input wire logic [39:0] aout_en,
  input wire logic [39:0] periph_en,
  input wire logic [39:0] periph_out,
  input wire logic [39:0] periph_oe_n,
  // Pads, peripheral inputs and edge events.
  output gpp_pkg::gpp_pad_s [4:0] pad,
  output logic [39:0] od_en,
  output logic [39:0] periph_in,
  output logic [39:0] edge_evt
);
  import gpp_pkg::*;

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [4:0][7:0] lat_ff, nxt_lat; // Output latches.
  logic [4:0][7:0] dir_ff, nxt_dir; // Direction registers.
  logic [4:0][7:0] ana_ff, nxt_ana; // Analog select registers.
  logic [4:0][7:0] wpu_ff, nxt_wpu; // Pull-up controls.
  logic [4:0][7:0] thr_ff, nxt_thr; // Threshold selects.
  logic [4:0][7:0] slr_ff, nxt_slr; // Slew controls.
  logic [4:0][7:0] odc_ff, nxt_odc; // Open-drain controls.
  logic [4:0][7:0] i2c_ff, nxt_i2c; // I2C pad controls per port.
  logic [4:0][7:0] rise_ff, nxt_rise; // Rising edge enables.
  logic [4:0][7:0] fall_ff, nxt_fall; // Falling edge enables.
  logic [7:0] nxt_rdata; // Next read data.
  logic [2:0][39:0] sync1_ff, sync2_ff, nxt_sync1, nxt_sync2; // Schmitt, TTL and I2C receivers, two stages each.
  logic [39:0] prev_ff, nxt_prev; // Input history for edge detection.
  logic [39:0] raw, din; // Chosen receiver, then the input after analog gating.
  gpp_pad_s [4:0] nxt_pad;
  logic [39:0] nxt_od, nxt_pin, nxt_edge;

  // Selects the threshold receiver for one pin.
  function automatic logic pick_in(input logic st_sel, input logic st, input logic ttl);
    pick_in = st_sel ? st : ttl;
  endfunction : pick_in

  // ----------------------------------------------------------------
  // Input path
  // ----------------------------------------------------------------
  // Synchronises every receiver first, so no logic reads an asynchronous pin; then picks and gates.
  always_comb begin
    nxt_sync1 = {pin_i2c, pin_ttl, pin_st};
    nxt_sync2 = sync1_ff;
    for (int i = 0; i < 40; i++) begin
      raw[i] = i2c_ff[i/8][GPP_I2C_THR_BIT] ? sync2_ff[2][i] :
        pick_in(thr_ff[i/8][i%8], sync2_ff[0][i], sync2_ff[1][i]);
    end
    din = raw & ~{ana_ff[4], ana_ff[3], ana_ff[2], ana_ff[1], ana_ff[0]} & pin_impl;
    nxt_prev = din;
    nxt_pin = din;
    nxt_edge = '0;
    for (int i = 0; i < 40; i++) begin
      nxt_edge[i] = (rise_ff[i/8][i%8] && din[i] && !prev_ff[i]) ||
        (fall_ff[i/8][i%8] && !din[i] && prev_ff[i]);
    end
  end

  // Registers the input path.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      prev_ff <= '0;
    end else if (clk_en) begin
      sync1_ff <= nxt_sync1;
      sync2_ff <= nxt_sync2;
      prev_ff <= nxt_prev;
    end
  end

  // ----------------------------------------------------------------
  // Register writes and reads
  // ----------------------------------------------------------------
  // Decodes one write and builds read data.
  always_comb begin
    logic [7:0] msk;
    logic [2:0] p;
    msk = '0;
    p = (req.port < 3'(GPP_PORTS)) ? req.port : 3'h0;
    msk = pin_impl[p*8 +: 8];
    nxt_lat = lat_ff;
    nxt_dir = dir_ff;
    nxt_ana = ana_ff;
    nxt_wpu = wpu_ff;
    nxt_thr = thr_ff;
    nxt_slr = slr_ff;
    nxt_odc = odc_ff;
    nxt_i2c = i2c_ff;
    nxt_rise = rise_ff;
    nxt_fall = fall_ff;
    nxt_rdata = 8'h00;
    if (req.port < 3'(GPP_PORTS)) begin
      if (req.wr_en) begin
        if (req.sel == GPP_SEL_PIN_LEVEL || req.sel == GPP_SEL_LATCH) begin
          nxt_lat[p] = req.wdata;
        end else if (req.sel == GPP_SEL_DIR) begin
          nxt_dir[p] = req.wdata;
        end else if (req.sel == GPP_SEL_ANALOG) begin
          nxt_ana[p] = req.wdata;
        end else if (req.sel == GPP_SEL_PULLUP) begin
          nxt_wpu[p] = req.wdata;
        end else if (req.sel == GPP_SEL_THRESH) begin
          nxt_thr[p] = req.wdata;
        end else if (req.sel == GPP_SEL_SLEW) begin
          nxt_slr[p] = req.wdata;
        end else if (req.sel == GPP_SEL_OPEN_DRAIN) begin
          nxt_odc[p] = req.wdata;
        end else if (req.sel == GPP_SEL_I2C_PAD) begin
          nxt_i2c[p] = req.wdata;
        end else if (req.sel == GPP_SEL_EDGE_RISE) begin
          nxt_rise[p] = req.wdata;
        end else if (req.sel == GPP_SEL_EDGE_FALL) begin
          nxt_fall[p] = req.wdata;
        end
      end
      if (req.sel == GPP_SEL_PIN_LEVEL) begin
        nxt_rdata = din[p*8 +: 8];
      end else if (req.sel == GPP_SEL_LATCH) begin
        nxt_rdata = lat_ff[p] & msk;
      end else if (req.sel == GPP_SEL_DIR) begin
        nxt_rdata = dir_ff[p] & msk;
      end else if (req.sel == GPP_SEL_ANALOG) begin
        nxt_rdata = ana_ff[p] & msk;
      end else if (req.sel == GPP_SEL_PULLUP) begin
        nxt_rdata = wpu_ff[p] & msk;
      end else if (req.sel == GPP_SEL_THRESH) begin
        nxt_rdata = thr_ff[p] & msk;
      end else if (req.sel == GPP_SEL_SLEW) begin
        nxt_rdata = slr_ff[p] & msk;
      end else if (req.sel == GPP_SEL_OPEN_DRAIN) begin
        nxt_rdata = odc_ff[p] & msk;
      end else if (req.sel == GPP_SEL_I2C_PAD) begin
        nxt_rdata = i2c_ff[p];
      end else if (req.sel == GPP_SEL_EDGE_RISE) begin
        nxt_rdata = rise_ff[p] & msk;
      end else if (req.sel == GPP_SEL_EDGE_FALL) begin
        nxt_rdata = fall_ff[p] & msk;
      end
    end
  end

  // Registers all control state and read data.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      lat_ff <= {GPP_PORTS{GPP_RST_LATCH}};
      dir_ff <= {GPP_PORTS{GPP_RST_DIR}};
      ana_ff <= {GPP_PORTS{GPP_RST_ANALOG}};
      wpu_ff <= {GPP_PORTS{GPP_RST_PULLUP}};
      thr_ff <= {GPP_PORTS{GPP_RST_THRESH}};
      slr_ff <= {GPP_PORTS{GPP_RST_SLEW}};
      odc_ff <= {GPP_PORTS{GPP_RST_ZERO}};
      i2c_ff <= {GPP_PORTS{GPP_RST_ZERO}};
      rise_ff <= {GPP_PORTS{GPP_RST_ZERO}};
      fall_ff <= {GPP_PORTS{GPP_RST_ZERO}};
      rdata <= 8'h00;
    end else if (clk_en) begin
      lat_ff <= nxt_lat;
      dir_ff <= nxt_dir;
      ana_ff <= nxt_ana;
      wpu_ff <= nxt_wpu;
      thr_ff <= nxt_thr;
      slr_ff <= nxt_slr;
      odc_ff <= nxt_odc;
      i2c_ff <= nxt_i2c;
      rise_ff <= nxt_rise;
      fall_ff <= nxt_fall;
      rdata <= nxt_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Output priority and pad control
  // ----------------------------------------------------------------
  // Resolves the owner per pin, then forms driver, pull-up and slew.
  always_comb begin
    gpp_own_e own;
    logic drv_n;
    logic val;
    own = GPP_OWN_LATCH;
    drv_n = 1'b1;
    val = 1'b0;
    nxt_pad = '0;
    nxt_od = '0;
    for (int i = 0; i < 40; i++) begin
      if (cfg_own[i]) begin
        own = GPP_OWN_CONFIG;
      end else if (aout_en[i]) begin
        own = GPP_OWN_ANALOG_OUT;
      end else if (periph_en[i]) begin
        own = GPP_OWN_PERIPH;
      end else begin
        own = GPP_OWN_LATCH;
      end
      case (own)
        GPP_OWN_CONFIG: begin
          drv_n = cfg_oe_n[i];
          val = cfg_out[i];
        end
        GPP_OWN_ANALOG_OUT: begin
          drv_n = 1'b1;
          val = 1'b0;
        end
        GPP_OWN_PERIPH: begin
          drv_n = periph_oe_n[i] | dir_ff[i/8][i%8];
          val = periph_out[i];
        end
        default: begin
          drv_n = dir_ff[i/8][i%8];
          val = lat_ff[i/8][i%8];
        end
      endcase
      drv_n = drv_n | ~pin_impl[i];
      if (odc_ff[i/8][i%8] && val) begin
        drv_n = 1'b1;
      end
      nxt_pad[i/8].drive_n[i%8] = drv_n;
      nxt_pad[i/8].out_val[i%8] = val;
      nxt_pad[i/8].pull_up[i%8] = wpu_ff[i/8][i%8] & dir_ff[i/8][i%8];
      nxt_pad[i/8].slew_lim[i%8] = slr_ff[i/8][i%8];
      nxt_pad[i/8].i2c_slew[i%8] = i2c_ff[i/8][GPP_I2C_SLEW_BIT];
      nxt_pad[i/8].i2c_pull[i%8] = i2c_ff[i/8][GPP_I2C_PULL_BIT];
      nxt_od[i] = odc_ff[i/8][i%8];
    end
  end

  // Registers pad controls, peripheral inputs and edge pulses.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pad <= {GPP_PORTS{{GPP_RST_DIR, GPP_RST_LATCH, GPP_RST_PULLUP, GPP_RST_SLEW, GPP_RST_ZERO, GPP_RST_ZERO}}};
      od_en <= '0;
      periph_in <= '0;
      edge_evt <= '0;
    end else if (clk_en) begin
      pad <= nxt_pad;
      od_en <= nxt_od;
      periph_in <= nxt_pin;
      edge_evt <= nxt_edge;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_latch_write;
    @(posedge ref_clk) disable iff (reset)
    (clk_en && req.wr_en && req.port == 3'h0 && req.sel == GPP_SEL_PIN_LEVEL) |=> (lat_ff[0] == $past(req.wdata));
  endproperty
  a_latch_write: assert property (p_latch_write) else $error("Port write did not load latch.");
  property p_analog_zero;
    @(posedge ref_clk) disable iff (reset)
    (clk_en && ana_ff[0][0]) |=> !(periph_in[0] && $past(ana_ff[0][0]) && $past(clk_en));
  endproperty
  a_analog_zero: assert property (p_analog_zero) else $error("Analog pin read as one.");
  property p_drive_dir;
    @(posedge ref_clk) disable iff (reset)
    (clk_en && !cfg_own[0] && !aout_en[0] && !periph_en[0] && pin_impl[0] && !odc_ff[0][0])
      |=> (pad[0].drive_n[0] == $past(dir_ff[0][0]));
  endproperty
  a_drive_dir: assert property (p_drive_dir) else $error("Driver does not follow direction.");
  property p_aout_hiz;
    @(posedge ref_clk) disable iff (reset)
    (clk_en && !cfg_own[1] && aout_en[1]) |=> pad[0].drive_n[1];
  endproperty
  a_aout_hiz: assert property (p_aout_hiz) else $error("Analog output did not tristate.");
  property p_pull_off;
    @(posedge ref_clk) disable iff (reset)
    (clk_en && !dir_ff[0][2]) |=> !pad[0].pull_up[2];
  endproperty
  a_pull_off: assert property (p_pull_off) else $error("Pull-up on for output pin.");
  property p_od_high;
    @(posedge ref_clk) disable iff (reset)
    (clk_en && odc_ff[0][3] && lat_ff[0][3] && !cfg_own[3] && !periph_en[3]) |=> pad[0].drive_n[3];
  endproperty
  a_od_high: assert property (p_od_high) else $error("Open-drain sourced high.");
  property p_rise_evt;
    @(posedge ref_clk) disable iff (reset)
    (clk_en && rise_ff[0][0] && din[0] && !prev_ff[0]) |=> edge_evt[0];
  endproperty
  a_rise_evt: assert property (p_rise_evt) else $error("Rising edge missed.");
  property p_slew;
    @(posedge ref_clk) disable iff (reset)
    clk_en |=> (pad[0].slew_lim == $past(slr_ff[0]));
  endproperty
  a_slew: assert property (p_slew) else $error("Slew control mismatch.");
  c_write: cover property (@(posedge ref_clk) clk_en && req.wr_en);
  c_edge: cover property (@(posedge ref_clk) |edge_evt);
  c_aout: cover property (@(posedge ref_clk) aout_en[1] && pad[0].drive_n[1]);
endmodule : gpp_port

// *** tb/gpp_pin_model.sv ***
// Purpose: Far-side model of the pins seen by the I/O port.
// Assumes: Pad controls come from the port; the bench sets any external source.
// Notes: A pin that nobody drives or pulls up toggles every cycle, so no stale level is read.
`timescale 1ns/10ps
module gpp_pin_model (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic reset,
  // Pad controls from the port.
  input wire gpp_pkg::gpp_pad_s [4:0] pad,
  // External source and threshold skew set by the bench.
  input wire logic [39:0] ext_en,
  input wire logic [39:0] ext_val,
  input wire logic [39:0] ttl_skew,
  // Receiver outputs back to the port.
  output logic [39:0] pin_st,
  output logic [39:0] pin_ttl,
  output logic [39:0] pin_i2c
);
  import gpp_pkg::*;
  logic flt_ff; // Level shown by a floating pin.
  logic [39:0] lvl; // Resolved pin level.
  // ----------------------------------------------------------------
  // Floating pattern
  // ----------------------------------------------------------------
  // Flips each cycle so a released pin never holds its last value.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      flt_ff <= 1'b0;
    end else begin
      flt_ff <= ~flt_ff;
    end
  end
  // ----------------------------------------------------------------
  // Level resolution
  // ----------------------------------------------------------------
  // Port drive wins, then the outside source, then the pull-up.
  always_comb begin
    for (int i = 0; i < 40; i++) begin
      if (!pad[i/8].drive_n[i%8]) begin
        lvl[i] = pad[i/8].out_val[i%8];
      end else if (ext_en[i]) begin
        lvl[i] = ext_val[i];
      end else if (pad[i/8].pull_up[i%8]) begin
        lvl[i] = 1'b1;
      end else begin
        lvl[i] = flt_ff;
      end
    end
  end
  // A skewed bit models a level between the two thresholds.
  assign pin_st = lvl;
  assign pin_ttl = lvl ^ ttl_skew;
  assign pin_i2c = lvl;
endmodule : gpp_pin_model

// *** tb/general_purpose_io_port_bench.sv ***
// Purpose: Self-checking bench for the general purpose I/O port.
// Assumes: The pin model closes the loop from pads back to receivers.
// Notes: Random accesses check registers; pin paths are checked in directed steps.
`timescale 1ns/10ps
module general_purpose_io_port_bench;
  import gpp_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic clk_en = 1'b1;
  gpp_req_s req = '0;
  logic [7:0] rdata;
  logic [39:0] pin_st, pin_ttl, pin_i2c, edge_evt, periph_in, od_en;
  logic [39:0] imp = 40'h0f_ffff_ffff; // Port 4 has four pins.
  logic [39:0] cfg_own = '0, cfg_out = '0, cfg_oe_n = '1, aout_en = '0;
  logic [39:0] per_en = '0, per_out = '0, per_oe_n = '1;
  logic [39:0] ext_en = '0, ext_val = '0, skew = '0;
  gpp_pad_s [4:0] pad;
  logic [7:0] shd [0:4][0:15]; // Expected register contents.
  logic [7:0] got, d;
  logic w;
  int num_errors = 0, n_compared = 0, p, s, i;
  // Clock of 10 ns.
  always #5 ref_clk = ~ref_clk;
  gpp_port gpp_port_i (.ref_clk(ref_clk), .reset(reset), .clk_en(clk_en), .req(req), .rdata(rdata),
    .pin_st(pin_st), .pin_ttl(pin_ttl), .pin_i2c(pin_i2c), .pin_impl(imp), .cfg_own(cfg_own),
    .cfg_out(cfg_out), .cfg_oe_n(cfg_oe_n), .aout_en(aout_en), .periph_en(per_en), .periph_out(per_out),
    .periph_oe_n(per_oe_n), .pad(pad), .od_en(od_en), .periph_in(periph_in), .edge_evt(edge_evt));
  gpp_pin_model gpp_pin_model_i (.ref_clk(ref_clk), .reset(reset), .pad(pad), .ext_en(ext_en),
    .ext_val(ext_val), .ttl_skew(skew), .pin_st(pin_st), .pin_ttl(pin_ttl), .pin_i2c(pin_i2c));
  // ----------------------------------------------------------------
  // Tasks and functions
  // ----------------------------------------------------------------
  // Register read as expected from the shadow copy.
  function automatic logic [7:0] exp_rd(input int pp, input int ss);
    if (pp > 4 || ss == 0 || ss > 10) begin
      return 8'h00;
    end
    return (ss == 8) ? shd[pp][ss] : shd[pp][ss] & imp[pp*8+:8];
  endfunction : exp_rd
  // Counts a comparison and reports a mismatch.
  task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // One access; returns the read data of that access.
  task automatic acc(input logic wr, input int pp, input int ss, input logic [7:0] wd, output logic [7:0] rd);
    @(posedge ref_clk);
    req <= '{wr, pp[2:0], ss[3:0], wd};
    @(posedge ref_clk);
    req <= '0;
    #1;
    rd = rdata;
    if (wr && pp < 5 && ss < 11) begin
      shd[pp][(ss == 0) ? 1 : ss] = wd;
    end
  endtask : acc
  // Lets synchroniser and pad registers catch up.
  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : settle
  // Prints the verdict and ends the run.
  task automatic wrap_up();
    if (num_errors == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : wrap_up
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h69a0));
    for (p = 0; p < 5; p++) begin
      for (s = 0; s < 16; s++) begin
        shd[p][s] = GPP_RST_ZERO;
      end
      shd[p][1] = GPP_RST_LATCH;
      shd[p][2] = GPP_RST_DIR;
      shd[p][3] = GPP_RST_ANALOG;
      shd[p][4] = GPP_RST_PULLUP;
      shd[p][5] = GPP_RST_THRESH;
      shd[p][6] = GPP_RST_SLEW;
    end
    settle(5);
    chk("drive_n in reset", 8'hff, pad[0].drive_n);
    chk("pull_up in reset", 8'h00, pad[0].pull_up);
    @(posedge ref_clk);
    reset <= 1'b0;
    // Reset values of every register of every port.
    for (p = 0; p < 5; p++) begin
      for (s = 1; s < 11; s++) begin
        acc(1'b0, p, s, 8'h00, got);
        chk("reset value", exp_rd(p, s), got);
      end
    end
    // Random writes and reads, bad ports and unknown selects included.
    for (i = 0; i < 80; i++) begin
      p = $urandom % 7;
      s = 1 + $urandom % 15;
      w = $urandom % 2;
      d = $urandom;
      acc(w, p, s, d, got);
      acc(1'b0, p, s, 8'h00, got);
      chk("register readback", exp_rd(p, s), got);
    end
    // Port 1 as a digital output driving a5; random I2C pad bits cleared first.
    acc(1'b1, 1, 8, 8'h00, got);
    acc(1'b1, 1, 3, 8'h00, got);
    acc(1'b1, 1, 5, 8'hff, got);
    acc(1'b1, 1, 7, 8'h00, got);
    acc(1'b1, 1, 0, 8'ha5, got);
    acc(1'b1, 1, 2, 8'h00, got);
    settle(8);
    chk("drive_n output", 8'h00, pad[1].drive_n);
    acc(1'b0, 1, 0, 8'h00, got);
    chk("pin read", 8'ha5, got);
    acc(1'b0, 1, 1, 8'h00, got);
    chk("latch read", 8'ha5, got);
    // A write while the clock enable is low must not land.
    @(posedge ref_clk);
    clk_en <= 1'b0;
    acc(1'b1, 1, 1, 8'h5a, got);
    @(posedge ref_clk);
    clk_en <= 1'b1;
    acc(1'b0, 1, 1, 8'h00, got);
    chk("latch frozen", 8'ha5, got);
    // Analog select blanks the input but not the output.
    acc(1'b1, 1, 3, 8'hff, got);
    settle(8);
    acc(1'b0, 1, 0, 8'h00, got);
    chk("analog pin read", 8'h00, got);
    chk("analog periph_in", 8'h00, periph_in[15:8]);
    chk("analog drive_n", 8'h00, pad[1].drive_n);
    chk("analog out_val", 8'ha5, pad[1].out_val);
    // Input from outside; thresholds disagree on every pin.
    acc(1'b1, 1, 3, 8'h00, got);
    acc(1'b1, 1, 2, 8'hff, got);
    @(posedge ref_clk);
    ext_en <= 40'h00_0000_ff00;
    ext_val <= 40'h00_0002_3c00;
    skew <= 40'h00_0000_ff00;
    settle(8);
    chk("drive_n input", 8'hff, pad[1].drive_n);
    acc(1'b0, 1, 0, 8'h00, got);
    chk("schmitt read", 8'h3c, got);
    acc(1'b1, 1, 5, 8'h00, got);
    settle(8);
    acc(1'b0, 1, 0, 8'h00, got);
    chk("ttl read", 8'hc3, got);
    chk("ttl periph_in", 8'hc3, periph_in[15:8]);
    // The I2C receiver has no skew, so the SMBus threshold reads the true level.
    acc(1'b1, 1, 8, 8'h07, got);
    settle(8);
    acc(1'b0, 1, 0, 8'h00, got);
    chk("i2c pin read", 8'h3c, got);
    chk("i2c slew", 8'hff, pad[1].i2c_slew);
    chk("i2c pull", 8'hff, pad[1].i2c_pull);
    acc(1'b1, 1, 8, 8'h00, got);
    acc(1'b1, 1, 5, 8'hff, got);
    // Pull-up follows its bit only while the pin is an input.
    acc(1'b1, 1, 4, 8'hff, got);
    acc(1'b1, 1, 6, 8'h0f, got);
    settle(4);
    chk("pull_up input", 8'hff, pad[1].pull_up);
    chk("slew_lim", 8'h0f, pad[1].slew_lim);
    acc(1'b1, 1, 2, 8'h00, got);
    settle(4);
    chk("pull_up output", 8'h00, pad[1].pull_up);
    acc(1'b0, 1, 4, 8'h00, got);
    chk("pull_up bit kept", 8'hff, got);
    // Open drain releases the high bits of a5.
    acc(1'b1, 1, 7, 8'hff, got);
    settle(4);
    chk("od_en", 8'hff, od_en[15:8]);
    chk("open drain drive_n", 8'ha5, pad[1].drive_n);
    acc(1'b1, 1, 7, 8'h00, got);
    // Owners of pin 0 of port 1, lowest to highest.
    @(posedge ref_clk);
    per_en[8] <= 1'b1;
    per_oe_n[8] <= 1'b0;
    per_out[8] <= 1'b0;
    settle(8);
    chk("periph out_val", 1'b0, pad[1].out_val[0]);
    acc(1'b0, 1, 0, 8'h00, got);
    chk("periph pin read", 8'ha4, got);
    @(posedge ref_clk);
    aout_en[8] <= 1'b1;
    settle(4);
    chk("analog out drive_n", 1'b1, pad[1].drive_n[0]);
    @(posedge ref_clk);
    cfg_own[8] <= 1'b1;
    cfg_out[8] <= 1'b1;
    cfg_oe_n[8] <= 1'b0;
    settle(4);
    chk("config drive_n", 1'b0, pad[1].drive_n[0]);
    chk("config out_val", 1'b1, pad[1].out_val[0]);
    // Edges on port 2: rise enabled on pin 0, fall on pin 1.
    acc(1'b1, 2, 3, 8'h00, got);
    acc(1'b1, 2, 2, 8'hff, got);
    @(posedge ref_clk);
    ext_en <= 40'h00_00ff_0000;
    acc(1'b1, 2, 9, 8'h01, got);
    acc(1'b1, 2, 10, 8'h02, got);
    settle(8);
    @(posedge ref_clk);
    ext_val <= 40'h00_0005_0000;
    for (i = 0; i < 10 && edge_evt[16] !== 1'b1; i++) begin
      @(posedge ref_clk) #1;
    end
    if (i == 10) begin
      num_errors++;
      wrap_up();
    end
    chk("edge events", 8'h03, edge_evt[23:16]);
    settle(1);
    chk("edge pulse ends", 8'h00, edge_evt[23:16]);
    wrap_up();
  end
endmodule : general_purpose_io_port_bench
